// [src/ltc_consts.vh]
// constants for the line transceiver clock select block
`ifndef LTC_CONSTS_VH
`define LTC_CONSTS_VH

// register indexes on the control ports
`define LTC_IDX_RESET_POWER   4'h0
`define LTC_IDX_LINK_STATUS   4'h1
`define LTC_IDX_ACT_REQ       4'h2
`define LTC_IDX_IRQ_FLAGS     4'h3
`define LTC_IDX_IRQ_ENABLES   4'h4
`define LTC_IDX_BEARER        4'h5
`define LTC_IDX_OPS_WORD      4'h6
`define LTC_IDX_CLOCK_CFG     4'h7

// clock_cfg fields
`define LTC_CFG_FREF_OUT_EN   0
`define LTC_CFG_DCL_FREQ_A    1
`define LTC_CFG_DCL_FREQ_B    2
`define LTC_CFG_TX_BAUD_EN    3

// reset values
`define LTC_RST_NIBBLE        4'h0
`define LTC_RST_OPS_WORD      12'h000
`define LTC_RST_CLOCK_CFG     4'h0

// oscillator model: enable ticks at twice 20.48 MHz from 100 MHz
`define LTC_STEP_NOMINAL      32'h68DB_8BAC
`define LTC_STEP_RANGE        32'h0001_B7CE
`define LTC_TRIM_LT           32'h0000_0001
`define LTC_TRIM_NT           32'h0000_0020

// ticks per period of reference, baud and half periods of clocks
`define LTC_TICKS_REF         13'h1400
`define LTC_TICKS_BAUD        13'h0200
`define LTC_LOCK_WINDOW       13'h0010
`define LTC_LOCK_COUNT        3'h7
`define LTC_HALF_512K         6'h28
`define LTC_HALF_2048K        6'h0A
`define LTC_HALF_2560K        6'h08
`define LTC_HALF_BAUD         9'h100

`endif

// [src/ltc_nco.v]
// phase accumulator giving oscillator tick enables
`timescale 1ns/100ps
module ltc_nco (
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire [31:0] step,
    output reg         tick_q
);
    reg  [31:0] acc_q;
    wire [32:0] sum;

    assign sum = {1'b0, acc_q} + {1'b0, step};

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            acc_q  <= 32'h0000_0000;
            tick_q <= 1'b0;
        end else begin
            acc_q  <= sum[31:0];
            tick_q <= sum[32];
        end
    end
endmodule // ltc_nco

// [src/ltc_clock_select.v]
// clock sourcing, clock output select and nibble registers
`timescale 1ns/100ps
`include "ltc_consts.vh"

// Overview of operation
// [RULE1] LT: oscillator tracks 8 kHz reference input
// [RULE2] NT: timing taken from recovered line baud
// [RULE3] register NT mode: reference pin outputs data clock
// [RULE4] two config bits choose data clock rate
// [RULE5] serial-bus mode: synced clock unless baud clock
// [RULE6] system drives rate select pin in NT
// [RULE7] NT data clock synced, three rates
// [RULE8] buffered oscillator is not a synced clock
// [RULE9] NT loop holds lock within 32 ppm
// [RULE10] LT loop about 1 Hz, slow trim
// [RULE11] registers govern only in host-register mode; code blocks writes, but held values other than act_reg_q and the reference pin enable still drive outputs
// [RULE12] parallel port reaches every control register
// [RULE13] link status bits: up, error, sync, transparent
// [RULE14] interrupt flags gated by enable nibble
module ltc_clock_select (
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire        host_mode_select,
    input  wire        nt_mode,
    input  wire        freq_ref_in,
    input  wire        line_baud_tick,
    input  wire        clock_rate_select_pin,
    input  wire        scp_wr,
    input  wire        scp_rd,
    input  wire [3:0]  scp_addr,
    input  wire [11:0] scp_wdata,
    input  wire        pcp_enable,
    input  wire        pcp_wr,
    input  wire        pcp_rd,
    input  wire [3:0]  pcp_addr,
    input  wire [11:0] pcp_wdata,
    input  wire [3:0]  link_state_in,
    input  wire [3:0]  irq_event,
    input  wire        ci_act_req,
    input  wire        ci_deact_req,
    output reg  [11:0] reg_rdata_q,
    output reg         reg_rvalid_q,
    output reg         irq_n_q,
    output reg  [3:0]  reset_power_q,
    output reg  [3:0]  act_ctrl_q,
    output reg  [3:0]  bearer_ctrl_q,
    output reg  [11:0] ops_word_q,
    output reg         freq_ref_out_q,
    output reg         freq_ref_oe_n_q,
    output reg         synced_clock_out_pin_q,
    output reg         data_clock_q,
    output reg         buffered_osc_out_q,
    output reg         pll_locked_q
);
    reg  [3:0]  act_reg_q;
    reg  [3:0]  irq_flags_q;
    reg  [3:0]  irq_en_q;
    reg  [3:0]  clock_cfg_q;
    reg  [31:0] step_q;
    reg  [12:0] phase_q;
    reg  [2:0]  lock_cnt_q;
    reg         ref_dly_q;
    reg  [5:0]  dcl_cnt_q;
    reg  [5:0]  sync_cnt_q;
    reg  [8:0]  baud_cnt_q;
    reg         sync_clk_q;
    reg         baud_clk_q;
    reg  [11:0] rdata_d;
    reg  [5:0]  dcl_half;
    reg  [5:0]  sync_half;

    wire        osc_tick;
    wire        wr;
    wire        rd;
    wire [3:0]  addr;
    wire [11:0] wdata;
    wire        regs_live;
    wire        event_in;
    wire [12:0] period;
    wire [31:0] trim;
    wire        phase_near;
    wire        rd_flags;

    ltc_nco u_nco (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .step    (step_q),
        .tick_q  (osc_tick)
    );

    // parallel port wins a same-cycle clash with the serial port
    assign wr    = (pcp_enable & pcp_wr) | scp_wr; // [RULE12]
    assign rd    = (pcp_enable & pcp_rd) | scp_rd;
    assign addr  = (pcp_enable & (pcp_wr | pcp_rd)) ? pcp_addr : scp_addr;
    assign wdata = (pcp_enable & pcp_wr) ? pcp_wdata : scp_wdata;
    assign regs_live = host_mode_select; // [RULE11]
    assign rd_flags  = rd & (addr == `LTC_IDX_IRQ_FLAGS);

    // phase detector event: line baud in NT, reference edge in LT
    assign event_in = nt_mode ? line_baud_tick // [RULE2]
                              : (freq_ref_in & ~ref_dly_q); // [RULE1]
    assign period = nt_mode ? `LTC_TICKS_BAUD : `LTC_TICKS_REF;
    assign trim   = nt_mode ? `LTC_TRIM_NT : `LTC_TRIM_LT; // [RULE10]
    assign phase_near = (phase_q < `LTC_LOCK_WINDOW) |
                        (phase_q > period - `LTC_LOCK_WINDOW);

    // register writes
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reset_power_q <= `LTC_RST_NIBBLE;
            act_reg_q     <= `LTC_RST_NIBBLE;
            irq_en_q      <= `LTC_RST_NIBBLE;
            bearer_ctrl_q <= `LTC_RST_NIBBLE;
            ops_word_q    <= `LTC_RST_OPS_WORD;
            clock_cfg_q   <= `LTC_RST_CLOCK_CFG;
        end else if (wr && regs_live) begin // [RULE11]
            case (addr)
                `LTC_IDX_RESET_POWER: reset_power_q <= wdata[3:0];
                `LTC_IDX_ACT_REQ:     act_reg_q     <= wdata[3:0];
                `LTC_IDX_IRQ_ENABLES: irq_en_q      <= wdata[3:0];
                `LTC_IDX_BEARER:      bearer_ctrl_q <= wdata[3:0];
                `LTC_IDX_OPS_WORD:    ops_word_q    <= wdata;
                `LTC_IDX_CLOCK_CFG:   clock_cfg_q   <= wdata[3:0];
                default: ;
            endcase
        end
    end

    // sticky flags, clear on read in host-register mode; a new event wins over the clear
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_flag
            always @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    irq_flags_q[gi] <= 1'b0;
                end else if (irq_event[gi]) begin
                    irq_flags_q[gi] <= 1'b1;
                end else if (rd_flags && regs_live) begin
                    irq_flags_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // read mux
    always @* begin
        rdata_d = 12'h000;
        case (addr)
            `LTC_IDX_RESET_POWER: rdata_d[3:0] = reset_power_q;
            `LTC_IDX_LINK_STATUS: rdata_d[3:0] = link_state_in; // [RULE13]
            `LTC_IDX_ACT_REQ:     rdata_d[3:0] = act_reg_q;
            `LTC_IDX_IRQ_FLAGS:   rdata_d[3:0] = irq_flags_q;
            `LTC_IDX_IRQ_ENABLES: rdata_d[3:0] = irq_en_q;
            `LTC_IDX_BEARER:      rdata_d[3:0] = bearer_ctrl_q;
            `LTC_IDX_OPS_WORD:    rdata_d      = ops_word_q;
            `LTC_IDX_CLOCK_CFG:   rdata_d[3:0] = clock_cfg_q;
            default:              rdata_d      = 12'h000;
        endcase
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q  <= 12'h000;
            reg_rvalid_q <= 1'b0;
            irq_n_q      <= 1'b1;
            act_ctrl_q   <= `LTC_RST_NIBBLE;
        end else begin
            reg_rvalid_q <= rd;
            if (rd) begin
                reg_rdata_q <= rdata_d;
            end
            irq_n_q <= ~|(irq_flags_q & irq_en_q); // [RULE14]
            if (regs_live) begin
                act_ctrl_q <= act_reg_q;
            end else begin
                act_ctrl_q <= {ci_act_req, ci_deact_req, 2'b00}; // [RULE11]
            end
        end
    end

    // bang-bang loop: nudge oscillator step once per event
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            step_q     <= `LTC_STEP_NOMINAL;
            phase_q    <= 13'h0000;
            lock_cnt_q <= 3'h0;
            pll_locked_q <= 1'b0;
            ref_dly_q  <= 1'b0;
        end else begin
            ref_dly_q <= freq_ref_in;
            if (osc_tick) begin
                if (phase_q >= period - 13'h0001) begin
                    phase_q <= 13'h0000;
                end else begin
                    phase_q <= phase_q + 13'h0001;
                end
            end
            if (event_in) begin
                // early wrap means fast oscillator; clamp to pull range
                if (phase_q < {1'b0, period[12:1]}) begin
                    if (step_q > `LTC_STEP_NOMINAL - `LTC_STEP_RANGE) begin
                        step_q <= step_q - trim; // [RULE1]
                    end
                end else if (step_q <
                             `LTC_STEP_NOMINAL + `LTC_STEP_RANGE) begin
                    step_q <= step_q + trim; // [RULE9]
                end
                if (!phase_near) begin
                    lock_cnt_q   <= 3'h0;
                    pll_locked_q <= 1'b0;
                end else if (lock_cnt_q == `LTC_LOCK_COUNT) begin
                    pll_locked_q <= 1'b1;
                end else begin
                    lock_cnt_q <= lock_cnt_q + 3'h1;
                end
            end
        end
    end

    // rate select: config bits for data clock, rate pin for synced out
    always @* begin
        if (clock_cfg_q[`LTC_CFG_DCL_FREQ_B]) begin // [RULE4]
            dcl_half = `LTC_HALF_2560K; // [RULE7]
        end else if (clock_cfg_q[`LTC_CFG_DCL_FREQ_A]) begin
            dcl_half = `LTC_HALF_2048K;
        end else begin
            dcl_half = `LTC_HALF_512K;
        end
        if (clock_rate_select_pin) begin // [RULE6]
            sync_half = `LTC_HALF_2048K;
        end else begin
            sync_half = `LTC_HALF_512K;
        end
    end

    // clock dividers driven from the tracked oscillator ticks
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dcl_cnt_q  <= 6'h00;
            sync_cnt_q <= 6'h00;
            baud_cnt_q <= 9'h000;
            data_clock_q <= 1'b0;
            sync_clk_q <= 1'b0;
            baud_clk_q <= 1'b0;
            buffered_osc_out_q <= 1'b0;
        end else if (osc_tick) begin
            // free oscillator view, not phase aligned to the line
            buffered_osc_out_q <= ~buffered_osc_out_q; // [RULE8]
            if (dcl_cnt_q >= dcl_half - 6'h01) begin
                dcl_cnt_q    <= 6'h00;
                data_clock_q <= ~data_clock_q; // [RULE7]
            end else begin
                dcl_cnt_q <= dcl_cnt_q + 6'h01;
            end
            if (sync_cnt_q >= sync_half - 6'h01) begin
                sync_cnt_q <= 6'h00;
                sync_clk_q <= ~sync_clk_q;
            end else begin
                sync_cnt_q <= sync_cnt_q + 6'h01;
            end
            if (baud_cnt_q == `LTC_HALF_BAUD - 9'h001) begin
                baud_cnt_q <= 9'h000;
                baud_clk_q <= ~baud_clk_q;
            end else begin
                baud_cnt_q <= baud_cnt_q + 9'h001;
            end
        end
    end

    // pin drive; reference pin stays an input unless enabled in NT
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            freq_ref_out_q  <= 1'b0;
            freq_ref_oe_n_q <= 1'b1;
            synced_clock_out_pin_q <= 1'b0;
        end else begin
            freq_ref_out_q  <= data_clock_q; // [RULE3]
            freq_ref_oe_n_q <= ~(host_mode_select & nt_mode &
                                 clock_cfg_q[`LTC_CFG_FREF_OUT_EN]); // [RULE3]
            if (clock_cfg_q[`LTC_CFG_TX_BAUD_EN]) begin
                synced_clock_out_pin_q <= baud_clk_q;
            end else begin
                synced_clock_out_pin_q <= sync_clk_q; // [RULE5]
            end
        end
    end
endmodule // ltc_clock_select

// [tb/ltc_sva.sv]
// checker for the clock select block ports
`timescale 1ns/100ps
module ltc_sva (
    input wire        clk_sys,
    input wire        rst_n,
    input wire        host_mode_select,
    input wire        nt_mode,
    input wire        scp_wr,
    input wire        scp_rd,
    input wire [3:0]  scp_addr,
    input wire [11:0] scp_wdata,
    input wire        pcp_enable,
    input wire        pcp_wr,
    input wire        pcp_rd,
    input wire [3:0]  link_state_in,
    input wire        ci_act_req,
    input wire        ci_deact_req,
    input wire [11:0] reg_rdata_q,
    input wire        reg_rvalid_q,
    input wire [3:0]  act_ctrl_q,
    input wire [3:0]  bearer_ctrl_q,
    input wire        freq_ref_oe_n_q
);
    wire rd = scp_rd | (pcp_enable & pcp_rd);
    wire wr = scp_wr | (pcp_enable & pcp_wr);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_rv; rd |=> reg_rvalid_q; endproperty
    a_rv: assert property (p_rv)
        else $error("read not answered");
    property p_nrv; !rd |=> !reg_rvalid_q; endproperty
    a_nrv: assert property (p_nrv)
        else $error("answer without read");
    property p_hold; !rd |=> $stable(reg_rdata_q); endproperty
    a_hold: assert property (p_hold)
        else $error("read data moved");
    property p_link;
        scp_rd && !pcp_rd && scp_addr == 4'h1
        |=> reg_rdata_q == {8'h00, $past(link_state_in)};
    endproperty
    a_link: assert property (p_link)
        else $error("link status read wrong");
    property p_oe;
        (!host_mode_select || !nt_mode) [*4] |-> freq_ref_oe_n_q;
    endproperty
    a_oe: assert property (p_oe)
        else $error("reference pin driven outside host nt mode");
    property p_ref; !host_mode_select && wr |=> $stable(bearer_ctrl_q);
    endproperty
    a_ref: assert property (p_ref)
        else $error("write taken in serial-bus mode");
    property p_act;
        !host_mode_select [*2]
        |-> act_ctrl_q == {$past(ci_act_req), $past(ci_deact_req), 2'b00};
    endproperty
    a_act: assert property (p_act)
        else $error("activation not from command channel");
    property p_bear;
        host_mode_select && scp_wr && !pcp_wr && scp_addr == 4'h5
        |=> bearer_ctrl_q == $past(scp_wdata[3:0]);
    endproperty
    a_bear: assert property (p_bear)
        else $error("bearer write lost");
    c_rd: cover property (rd ##1 reg_rvalid_q);
    c_oe: cover property (!freq_ref_oe_n_q);
    c_ser: cover property (!host_mode_select && scp_wr);
endmodule // ltc_sva

// [tb/ltc_line_model.sv]
// far side model: 8 kHz reference and recovered baud ticks
`timescale 1ns/100ps
module ltc_line_model (
    input  wire clk_sys,
    output reg  freq_ref_in = 1'b0,
    output reg  line_baud_tick = 1'b0
);
    integer n_ref = 0;
    integer n_baud = 0;
    // half period of 8 kHz is 6250 cycles
    always @(posedge clk_sys) begin
        n_ref <= (n_ref == 6249) ? 0 : n_ref + 1;
        if (n_ref == 6249) freq_ref_in <= !freq_ref_in;
    end
    // 80 kbaud nominal, well inside 32 ppm; osc buffer left unused
    always @(posedge clk_sys) begin
        n_baud <= (n_baud == 1249) ? 0 : n_baud + 1;
        line_baud_tick <= (n_baud == 1249);
    end
endmodule // ltc_line_model

// [tb/tb.sv]
// self-checking bench for the clock select block
`timescale 1ns/100ps
module tb;
    reg         clk_sys = 1'b0, rst_n = 1'b0, host_mode_select = 1'b1;
    reg         nt_mode = 1'b1, clock_rate_select_pin = 1'b0;
    reg         scp_wr = 1'b0, scp_rd = 1'b0, pcp_enable = 1'b1;
    reg         pcp_wr = 1'b0, pcp_rd = 1'b0, ci_act_req = 1'b0;
    reg         ci_deact_req = 1'b0, p_ref = 1'b0, p_syn = 1'b0;
    reg  [3:0]  scp_addr = 4'h0, pcp_addr = 4'h0;
    reg  [11:0] scp_wdata = 12'h000, pcp_wdata = 12'h000;
    reg  [3:0]  link_state_in = 4'h9, irq_event = 4'h0;
    reg  [27:0] rows [0:8];
    wire        freq_ref_in, line_baud_tick, reg_rvalid_q, irq_n_q;
    wire        freq_ref_out_q, freq_ref_oe_n_q, synced_clock_out_pin_q;
    wire        data_clock_q, buffered_osc_out_q, pll_locked_q;
    wire [11:0] reg_rdata_q, ops_word_q;
    wire [3:0]  reset_power_q, act_ctrl_q, bearer_ctrl_q;
    integer     fails = 0, n_tests = 0, i, k, e_ref = 0, e_syn = 0;
    ltc_clock_select ltc_clock_select_i (.*);
    ltc_line_model ltc_line_model_i (.*);
    initial forever #5 clk_sys = !clk_sys;
    always @(posedge clk_sys) begin
        p_ref <= freq_ref_out_q;
        p_syn <= synced_clock_out_pin_q;
        if (p_ref !== freq_ref_out_q) e_ref <= e_ref + 1;
        if (p_syn !== synced_clock_out_pin_q) e_syn <= e_syn + 1;
    end
    task finish_test;
        begin
            if (fails == 0 && n_tests > 0) $display("All tests passed");
            else $display("Some tests failed");
            $finish;
        end
    endtask
    task chk(input [11:0] got, input [11:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("MISMATCH %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    task wr(input p, input [3:0] a, input [11:0] d);
        begin
            @(posedge clk_sys);
            scp_wr <= !p;
            pcp_wr <= p;
            {scp_addr, pcp_addr, scp_wdata, pcp_wdata} <= {a, a, d, d};
            @(posedge clk_sys);
            {scp_wr, pcp_wr} <= 2'b00;
        end
    endtask
    task rd(input p, input [3:0] a, input [11:0] exp);
        begin
            @(posedge clk_sys);
            scp_rd <= !p;
            pcp_rd <= p;
            {scp_addr, pcp_addr} <= {a, a};
            @(posedge clk_sys);
            {scp_rd, pcp_rd} <= 2'b00;
            #1;
            chk({11'h000, reg_rvalid_q}, 12'h001);
            chk(reg_rdata_q, exp);
        end
    endtask
    // toggles seen over 800 cycles, one either way allowed
    task rate(input s, input integer exp);
        integer c;
        begin
            repeat (100) @(posedge clk_sys);
            c = s ? e_syn : e_ref;
            repeat (800) @(posedge clk_sys);
            c = (s ? e_syn : e_ref) - c - exp;
            n_tests = n_tests + 1;
            if (c > 1 || c < -1) begin
                fails = fails + 1;
                $display("MISMATCH %0t clock rate off by %0d", $time, c);
            end
        end
    endtask
    task pulse(input [3:0] e, input x);
        begin
            @(posedge clk_sys);
            irq_event <= e;
            @(posedge clk_sys);
            irq_event <= 4'h0;
            repeat (3) @(posedge clk_sys);
            #1;
            chk({11'h000, irq_n_q}, {11'h000, x});
        end
    endtask
    initial begin
        #1_000_000;
        fails = fails + 1;
        finish_test;
    end
    initial begin
        rows[0] = 28'h0_005_005;
        rows[1] = 28'h1_00F_009;
        rows[2] = 28'h2_00A_00A;
        rows[3] = 28'h3_00F_000;
        rows[4] = 28'h4_002_002;
        rows[5] = 28'h5_003_003;
        rows[6] = 28'h6_ABC_ABC;
        rows[7] = 28'h8_FFF_000;
        rows[8] = 28'h7_001_001;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (i = 0; i < 8; i = i + 1)
            rd(i[0], i[3:0], (i == 1) ? 12'h009 : 12'h000);
        for (i = 0; i < 9; i = i + 1) begin
            wr(!i[0], rows[i][27:24], rows[i][23:12]);
            rd(i[0], rows[i][27:24], rows[i][11:0]);
        end
        chk({11'h000, freq_ref_oe_n_q}, 12'h000);
        for (k = 0; k < 3; k = k + 1) begin
            wr(0, 4'h7, (k == 0) ? 12'h001 : (k == 1) ? 12'h003 : 12'h005);
            rate(0, (k == 0) ? 8 : (k == 1) ? 33 : 41);
        end
        pulse(4'h1, 1'b1);
        pulse(4'h2, 1'b0);
        rd(0, 4'h3, 12'h003);
        pulse(4'h0, 1'b1);
        host_mode_select <= 1'b0;
        ci_act_req <= 1'b1;
        wr(0, 4'h5, 12'h00C);
        repeat (3) @(posedge clk_sys);
        #1;
        chk({8'h00, bearer_ctrl_q}, 12'h003);
        chk({8'h00, act_ctrl_q}, 12'h008);
        chk({11'h000, freq_ref_oe_n_q}, 12'h001);
        for (k = 0; k < 2; k = k + 1) begin
            clock_rate_select_pin <= !k[0];
            rate(1, k ? 8 : 33);
        end
        rst_n <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk(ops_word_q, 12'h000);
        chk({11'h000, irq_n_q}, 12'h001);
        finish_test;
    end
endmodule // tb
bind ltc_clock_select ltc_sva ltc_sva_i (.*);
